/* File: core/icl_pkg.sv */
// Purpose: Shared constants for the input clock lock configuration block
// Assumes: Classic Wishbone, 32-bit data, one word per register
// Notes:   Rate codes 12 to 15 are unsupported and stop the divider except in integer or composite mode

package icl_pkg;

   // ----------------------------------------
   // Sizes
   // ----------------------------------------
   localparam int NUM_IN = 14;
   localparam int RAT_W  = 16;
   localparam int DIV_W  = 15;
   localparam int CFG_W  = 6;

   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [7:0] OFS_MAIN3 = 8'h00;
   localparam logic [7:0] OFS_MAIN5 = 8'h04;
   localparam logic [7:0] OFS_TEST_CONTROL_ONE = 8'h08;
   localparam logic [7:0] OFS_INTEGER_DIVIDE_VALUE  = 8'h0C;
   localparam logic [7:0] OFS_ICR0  = 8'h10;
   localparam logic [7:0] OFS_STAT  = 8'h48;

   // ----------------------------------------
   // Fields of each input config register and of the status register
   // ----------------------------------------
   localparam int CFG_RATE_LSB = 0;
   localparam int CFG_L8K_BIT  = 4;
   localparam int CFG_INTEGER_DIVIDE_VALUE_BIT = 5;
   localparam int STAT_L8K_LSB = 16;

   // ----------------------------------------
   // Rate codes
   // ----------------------------------------
   localparam logic [3:0] RC_2K     = 4'h0;
   localparam logic [3:0] RC_4K     = 4'h1;
   localparam logic [3:0] RC_8K     = 4'h2;
   localparam logic [3:0] RC_PRI    = 4'h3;
   localparam logic [3:0] RC_6M312  = 4'h4;
   localparam logic [3:0] RC_6M48   = 4'h5;
   localparam logic [3:0] RC_19M44  = 4'h6;
   localparam logic [3:0] RC_25M92  = 4'h7;
   localparam logic [3:0] RC_38M88  = 4'h8;
   localparam logic [3:0] RC_51M84  = 4'h9;
   localparam logic [3:0] RC_77M76  = 4'hA;
   localparam logic [3:0] RC_155M52 = 4'hB;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   // Input fourteen down to input one
   localparam logic [55:0] RST_RATE  = 56'h3336666666_2222;
   localparam logic [13:0] DIFF_MASK = 14'h0030;
   localparam logic [DIV_W-1:0] RST_INTEGER_DIVIDE_VALUE = 15'h0001;
   localparam int IN_ELEVEN = 10;
   localparam logic [RAT_W-1:0] RAT_ONE  = 16'h0001;
   localparam logic [RAT_W-1:0] RAT_HALF = 16'h0002;

   typedef enum logic [1:0] {
      ICL_DIRECT = 2'b00,
      ICL_LOCK_AT_EIGHT_KHZ_SELECT = 2'b01,
      ICL_INTEGER_DIVIDE_VALUE   = 2'b11
   } icl_mode_e;

   // Reference cycles per 8kHz period; zero marks no fixed ratio
   function automatic logic [RAT_W-1:0] f8k_ratio(input logic [3:0] c,
                                                 input logic       son);
      case (c)
         RC_8K:     return 16'h0001;
         RC_PRI:    return son ? 16'h00C1 : 16'h0100;
         RC_6M312:  return 16'h0315;
         RC_6M48:   return 16'h032A;
         RC_19M44:  return 16'h097E;
         RC_25M92:  return 16'h0CA8;
         RC_38M88:  return 16'h12FC;
         RC_51M84:  return 16'h1950;
         RC_77M76:  return 16'h25F8;
         RC_155M52: return 16'h4BF0;
         default:   return 16'h0000;
      endcase
   endfunction : f8k_ratio

endpackage : icl_pkg

/* File: core/icl_ref_div.sv */
// Purpose: Per-input reference synchroniser and locking divider
// Assumes: Reference no faster than a quarter of clk_i, each level held two clk_i cycles
// Notes:   Counter restarts whenever mode or ratio changes

`timescale 1ns/1ps
`default_nettype none

module icl_ref_div (
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   input  wire logic                     ce_i,
   input  wire logic                     ref_i,
   input  wire logic                     use_pulse_i,
   input  wire logic                     pulse_i,
   input  wire logic                     edge_pol_i,
   input  wire icl_pkg::icl_mode_e       mode_i,
   input  wire logic [icl_pkg::RAT_W-1:0] ratio_i,
   output logic                          tick_o
);

   logic                      s1_reg, s2_reg, s3_reg, lvl_reg;
   logic [icl_pkg::RAT_W-1:0] cnt_reg, ratio_q;
   icl_pkg::icl_mode_e        mode_q;
   logic                      chg, rise, fall, evt, cfg_chg, tick_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_reg  <= 1'b0;
         s2_reg  <= 1'b0;
         s3_reg  <= 1'b0;
         lvl_reg <= 1'b0;
      end else if (ce_i) begin
         s1_reg <= ref_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            lvl_reg <= s3_reg;
         end
      end
   end

   assign chg  = (s2_reg == s3_reg) && (s3_reg != lvl_reg);
   assign rise = chg && s3_reg;
   assign fall = chg && !s3_reg;
   // Edge choice only matters when dividing to 8kHz
   assign evt  = use_pulse_i ? pulse_i :
                 ((mode_i == icl_pkg::ICL_LOCK_AT_EIGHT_KHZ_SELECT && edge_pol_i) ? fall : rise);
   assign cfg_chg = (ratio_i != ratio_q) || (mode_i != mode_q);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_reg  <= '0;
         ratio_q  <= '0;
         mode_q   <= icl_pkg::ICL_DIRECT;
         tick_reg <= 1'b0;
      end else if (ce_i) begin
         ratio_q  <= ratio_i;
         mode_q   <= mode_i;
         tick_reg <= 1'b0;
         if (cfg_chg) begin
            cnt_reg <= '0;
         end else if (evt && ratio_i != '0) begin
            if (cnt_reg >= ratio_i - icl_pkg::RAT_ONE) begin
               cnt_reg  <= '0;
               tick_reg <= 1'b1;
            end else begin
               cnt_reg <= cnt_reg + icl_pkg::RAT_ONE;
            end
         end
      end
   end

   assign tick_o = tick_reg;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_div_wrap: assert property (
      (ce_i && !cfg_chg && evt && ratio_i != '0 && cnt_reg == ratio_i - icl_pkg::RAT_ONE)
      |=> tick_reg) else $error("divider missed its terminal count");
   chk_div_restart: assert property (
      (ce_i && cfg_chg) |=> (cnt_reg == '0 && !tick_reg))
      else $error("divider not restarted on config change");

endmodule : icl_ref_div

`default_nettype wire

/* File: core/icl_top.sv */
// Purpose: Input clock configuration and locking pre-division
// Assumes: Classic Wishbone slave, one-cycle ack, straps steady in reset
// Notes:   Reset wins over the clock enable
//
// Behaviour
// - Regional bit picks 1.544MHz or 2.048MHz
// - Regional bit reset value taken from pin
// - Inputs one, two default composite clock receivers
// - Composite mode forwards only recovered 8kHz
// - Format bit makes input one/two single-ended
// - Divider and lock-8k bits decode locking mode
// - Direct lock uses the programmed rate code
// - 155.52MHz direct lock is halved first
// - Lock-8k mode divides reference to 8kHz
// - Polarity bit picks edge in lock-8k
// - 2kHz and 4kHz ignore lock-8k bit
// - Integer mode divides by value plus one
// - One shared divide factor for all inputs
// - Integer mode ignores the rate code
// - Input eleven default follows primary/secondary select
// - Inputs twelve to fourteen default regional rate
// - Rate set per input format, 155.52MHz differential
//
// Added by the designer: the address map and register access over Wishbone.

`timescale 1ns/1ps
`default_nettype none

module icl_top (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic        wb_we_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        regional_rate_select_i,
   input  wire logic        primary_secondary_select_i,
   input  wire logic [13:0] ref_clk_i,
   input  wire logic [1:0]  cc_pos_i,
   input  wire logic [1:0]  cc_neg_i,
   output logic      [13:0] lock_tick_o,
   output logic      [13:0] lock_at_8k_o
);

   localparam int N = icl_pkg::NUM_IN;
   localparam int W = icl_pkg::RAT_W;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic                         strap_r1, strap_r2, strap_r3;
   logic                         strap_p1, strap_p2, strap_p3;
   logic                         regional_reg;
   logic [1:0]                   fmt_sel_reg;
   logic                         sync_edge_polarity_reg;
   logic [icl_pkg::DIV_W-1:0]    integer_divide_value_reg;
   logic [icl_pkg::CFG_W-1:0]    cfg_reg [N];
   logic                         ack_reg;
   logic [31:0]                  rdat_reg, rdat_next;
   logic                         wr_en, rd_en;
   logic [N-1:0]                 unsup, use_pulse, cc_pulse, l8k_reg;
   icl_pkg::icl_mode_e           mode [N];
   logic [W-1:0]                 ratio [N];
   logic [1:0]                   cp1, cp2, cp3, cn1, cn2, cn3;
   logic [1:0]                   cp_lvl, cn_lvl, cp_rise, cn_rise;
   logic [1:0]                   cc_mark, cc_last_reg, cc_seen_reg, cc_bpv_reg;
   logic [1:0]                   cc_bpv;

   // ----------------------------------------
   // Strap synchronisers
   // ----------------------------------------
   // Not reset so that the strap level is already through during reset
   always_ff @(posedge clk_i) begin
      if (ce_i || rst_i) begin
         strap_r1 <= regional_rate_select_i;
         strap_r2 <= strap_r1;
         strap_r3 <= strap_r2;
         strap_p1 <= primary_secondary_select_i;
         strap_p2 <= strap_p1;
         strap_p3 <= strap_p2;
      end
   end

   // ----------------------------------------
   // Wishbone slave
   // ----------------------------------------
   assign rd_en = wb_cyc_i && wb_stb_i && !ack_reg;
   // Writes land at the edge where the master sees ack
   assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
      end else if (ce_i) begin
         ack_reg <= rd_en;
      end
   end

   always_comb begin
      rdat_next = 32'h0000_0000;
      case (wb_adr_i[7:2])
         icl_pkg::OFS_MAIN3[7:2]: rdat_next[0] = regional_reg;
         icl_pkg::OFS_MAIN5[7:2]: rdat_next[1:0] = fmt_sel_reg;
         icl_pkg::OFS_TEST_CONTROL_ONE[7:2]: rdat_next[0] = sync_edge_polarity_reg;
         icl_pkg::OFS_INTEGER_DIVIDE_VALUE[7:2]:
            rdat_next[icl_pkg::DIV_W-1:0] = integer_divide_value_reg;
         icl_pkg::OFS_STAT[7:2]: begin
            rdat_next[N-1:0] = unsup;
            rdat_next[icl_pkg::STAT_L8K_LSB +: N] = l8k_reg;
         end
         default: begin
            for (int k = 0; k < N; k++) begin
               if (wb_adr_i[7:2] == 6'(icl_pkg::OFS_ICR0[7:2] + k)) begin
                  rdat_next[icl_pkg::CFG_W-1:0] = cfg_reg[k];
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdat_reg <= 32'h0000_0000;
      end else if (ce_i && rd_en) begin
         rdat_reg <= rdat_next;
      end
   end

   assign wb_dat_o = rdat_reg;
   assign wb_ack_o = ack_reg;

   // ----------------------------------------
   // Global configuration
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         regional_reg <= strap_r3;
      end else if (ce_i && wr_en && wb_sel_i[0] &&
                   wb_adr_i[7:2] == icl_pkg::OFS_MAIN3[7:2]) begin
         regional_reg <= wb_dat_i[0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fmt_sel_reg <= 2'h0;
      end else if (ce_i && wr_en && wb_sel_i[0] &&
                   wb_adr_i[7:2] == icl_pkg::OFS_MAIN5[7:2]) begin
         fmt_sel_reg <= wb_dat_i[1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync_edge_polarity_reg <= 1'b0;
      end else if (ce_i && wr_en && wb_sel_i[0] &&
                   wb_adr_i[7:2] == icl_pkg::OFS_TEST_CONTROL_ONE[7:2]) begin
         sync_edge_polarity_reg <= wb_dat_i[0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         integer_divide_value_reg <= icl_pkg::RST_INTEGER_DIVIDE_VALUE;
      end else if (ce_i && wr_en &&
                   wb_adr_i[7:2] == icl_pkg::OFS_INTEGER_DIVIDE_VALUE[7:2]) begin
         if (wb_sel_i[0]) begin
            integer_divide_value_reg[7:0] <= wb_dat_i[7:0];
         end
         if (wb_sel_i[1]) begin
            integer_divide_value_reg[14:8] <= wb_dat_i[14:8];
         end
      end
   end

   // ----------------------------------------
   // Per-input config registers
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int k = 0; k < N; k++) begin
            cfg_reg[k] <= {2'b00, icl_pkg::RST_RATE[4*k +: 4]};
         end
         cfg_reg[icl_pkg::IN_ELEVEN] <=
            {2'b00, strap_p3 ? icl_pkg::RC_19M44 : icl_pkg::RC_6M48};
      end else if (ce_i && wr_en && wb_sel_i[0]) begin
         for (int k = 0; k < N; k++) begin
            if (wb_adr_i[7:2] == 6'(icl_pkg::OFS_ICR0[7:2] + k)) begin
               cfg_reg[k] <= wb_dat_i[icl_pkg::CFG_W-1:0];
            end
         end
      end
   end

   // ----------------------------------------
   // Composite clock receivers
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cp1    <= 2'h0;
         cp2    <= 2'h0;
         cp3    <= 2'h0;
         cn1    <= 2'h0;
         cn2    <= 2'h0;
         cn3    <= 2'h0;
         cp_lvl <= 2'h0;
         cn_lvl <= 2'h0;
      end else if (ce_i) begin
         cp1 <= cc_pos_i;
         cp2 <= cp1;
         cp3 <= cp2;
         cn1 <= cc_neg_i;
         cn2 <= cn1;
         cn3 <= cn2;
         cp_lvl <= (cp2 & ~(cp2 ^ cp3)) | (cp_lvl & (cp2 ^ cp3));
         cn_lvl <= (cn2 & ~(cn2 ^ cn3)) | (cn_lvl & (cn2 ^ cn3));
      end
   end

   assign cp_rise = cp3 & ~(cp2 ^ cp3) & ~cp_lvl;
   assign cn_rise = cn3 & ~(cn2 ^ cn3) & ~cn_lvl;
   assign cc_mark = cp_rise | cn_rise;
   // A mark of the same polarity as the last one is the 8kHz violation
   assign cc_bpv  = cc_mark & cc_seen_reg & ~(cp_rise ^ cc_last_reg);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cc_last_reg <= 2'h0;
         cc_seen_reg <= 2'h0;
         cc_bpv_reg  <= 2'h0;
      end else if (ce_i) begin
         cc_bpv_reg  <= cc_bpv;
         cc_seen_reg <= cc_seen_reg | cc_mark;
         cc_last_reg <= (cc_last_reg & ~cc_mark) | (cp_rise & cc_mark);
      end
   end

   // ----------------------------------------
   // Mode decode and divide ratio per input
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < N; gi++) begin : g_in
         logic [3:0] rate;
         logic       fast_ok;
         assign rate    = cfg_reg[gi][icl_pkg::CFG_RATE_LSB +: 4];
         assign fast_ok = icl_pkg::DIFF_MASK[gi];
         if (gi < 2) begin : g_cc
            assign use_pulse[gi] = !fmt_sel_reg[gi];
            assign cc_pulse[gi]  = cc_bpv_reg[gi];
         end else begin : g_se
            assign use_pulse[gi] = 1'b0;
            assign cc_pulse[gi]  = 1'b0;
         end

         always_comb begin
            if (cfg_reg[gi][icl_pkg::CFG_INTEGER_DIVIDE_VALUE_BIT]) begin
               mode[gi] = icl_pkg::ICL_INTEGER_DIVIDE_VALUE;
            end else if (cfg_reg[gi][icl_pkg::CFG_L8K_BIT] &&
                         rate != icl_pkg::RC_2K && rate != icl_pkg::RC_4K) begin
               mode[gi] = icl_pkg::ICL_LOCK_AT_EIGHT_KHZ_SELECT;
            end else begin
               mode[gi] = icl_pkg::ICL_DIRECT;
            end
         end

         always_comb begin
            unsup[gi] = 1'b0;
            ratio[gi] = icl_pkg::RAT_ONE;
            if (use_pulse[gi]) begin
               ratio[gi] = icl_pkg::RAT_ONE;
            end else if (mode[gi] == icl_pkg::ICL_INTEGER_DIVIDE_VALUE) begin
               // Rate code plays no part here
               ratio[gi] = W'(integer_divide_value_reg) + icl_pkg::RAT_ONE;
            end else if (rate > icl_pkg::RC_155M52 ||
                         (rate == icl_pkg::RC_155M52 && !fast_ok)) begin
               unsup[gi] = 1'b1;
               ratio[gi] = '0;
            end else if (mode[gi] == icl_pkg::ICL_LOCK_AT_EIGHT_KHZ_SELECT) begin
               ratio[gi] = icl_pkg::f8k_ratio(rate, regional_reg);
            end else if (rate == icl_pkg::RC_155M52) begin
               ratio[gi] = icl_pkg::RAT_HALF;
            end else begin
               ratio[gi] = icl_pkg::RAT_ONE;
            end
         end

         icl_ref_div u_div (
            .clk_i       (clk_i),
            .rst_i       (rst_i),
            .ce_i        (ce_i),
            .ref_i       (ref_clk_i[gi]),
            .use_pulse_i (use_pulse[gi]),
            .pulse_i     (cc_pulse[gi]),
            .edge_pol_i  (sync_edge_polarity_reg),
            .mode_i      (mode[gi]),
            .ratio_i     (ratio[gi]),
            .tick_o      (lock_tick_o[gi])
         );
      end
   endgenerate

   // ----------------------------------------
   // Lock rate indication
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         l8k_reg <= '0;
      end else if (ce_i) begin
         for (int k = 0; k < N; k++) begin
            l8k_reg[k] <= use_pulse[k] || (mode[k] != icl_pkg::ICL_DIRECT);
         end
      end
   end

   assign lock_at_8k_o = l8k_reg;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
   endsequence

   sequence s_ack_done;
      wb_ack_o ##1 (!wb_ack_o || !ce_i);
   endsequence

   chk_bus_ack_once:
      assert property (s_req |=> s_ack_done)
      else $error("ack not given for exactly one cycle");

   // Waits until the strap chain has filled, so an empty chain is never compared
   chk_strap_load:
      assert property (disable iff (1'b0)
         (rst_i && strap_r2 == strap_r3) |=> (regional_reg == $past(strap_r3)))
      else $error("regional bit not loaded from strap in reset");

   chk_region_ratio:
      assert property ((mode[12] == icl_pkg::ICL_LOCK_AT_EIGHT_KHZ_SELECT &&
                        g_in[12].rate == icl_pkg::RC_PRI) |->
                       (ratio[12] == (regional_reg ? 16'h00C1 : 16'h0100)))
      else $error("regional rate not honoured");

   chk_cc_forward:
      assert property ((!fmt_sel_reg[0] && $stable(fmt_sel_reg[0]) && lock_tick_o[0])
                       |-> $past(cc_bpv_reg[0]))
      else $error("composite input forwarded a non-violation edge");

   chk_cc_violation:
      assert property ((ce_i && cc_mark[0] && cc_seen_reg[0] &&
                        (cp_rise[0] == cc_last_reg[0])) |=> cc_bpv_reg[0])
      else $error("bipolar violation not recovered");

   chk_mode_integer_divide_value:
      assert property (cfg_reg[3][icl_pkg::CFG_INTEGER_DIVIDE_VALUE_BIT] |->
                       (mode[3] == icl_pkg::ICL_INTEGER_DIVIDE_VALUE &&
                        ratio[3] == W'(integer_divide_value_reg) + icl_pkg::RAT_ONE))
      else $error("integer divide mode decoded wrongly");

   chk_low_rate_direct:
      assert property ((!cfg_reg[3][icl_pkg::CFG_INTEGER_DIVIDE_VALUE_BIT] &&
                        g_in[3].rate <= icl_pkg::RC_4K) |->
                       mode[3] == icl_pkg::ICL_DIRECT)
      else $error("low rate input left direct lock");

   chk_halve_fast:
      assert property ((mode[5] == icl_pkg::ICL_DIRECT &&
                        g_in[5].rate == icl_pkg::RC_155M52) |->
                       ratio[5] == icl_pkg::RAT_HALF)
      else $error("fast differential reference not halved");

   chk_lock_at_eight_khz_select_ratio:
      assert property ((mode[7] == icl_pkg::ICL_LOCK_AT_EIGHT_KHZ_SELECT &&
                        g_in[7].rate == icl_pkg::RC_19M44) |->
                       ratio[7] == 16'h097E)
      else $error("divide-to-8kHz ratio wrong");

   chk_reset_defaults:
      assert property (disable iff (1'b0)
         ($past(rst_i) && !rst_i) |->
         (g_in[10].rate == ($past(strap_p3) ? icl_pkg::RC_19M44 : icl_pkg::RC_6M48) &&
          g_in[13].rate == icl_pkg::RC_PRI))
      else $error("input defaults wrong after reset");

   chk_single_ended_fast:
      assert property ((!cfg_reg[8][icl_pkg::CFG_INTEGER_DIVIDE_VALUE_BIT] &&
                        g_in[8].rate == icl_pkg::RC_155M52) |=> !lock_tick_o[8])
      else $error("single-ended input locked at 155.52MHz");

endmodule : icl_top

`default_nettype wire

/* File: verif/icl_ref_src.sv */
// Purpose: Reference pin and composite clock sources
// Assumes: Sources much slower than clk_i
// Notes:   Clocks run free; composite rails idle low
`timescale 1ns/1ps
`default_nettype none
module icl_ref_src #(parameter int HALF = 4) (
   input  wire logic        clk_i,
   output logic      [13:0] ref_clk_o,
   output logic      [1:0]  cc_pos_o,
   output logic      [1:0]  cc_neg_o
);
   // ---------------------
   // Sources
   // ---------------------
   int   ph  = 0;
   int   mk  = 0;
   logic pol = 1'b0;
   initial begin
      ref_clk_o = 14'h0000;
      cc_pos_o  = 2'h0;
      cc_neg_o  = 2'h0;
   end
   always @(posedge clk_i) begin
      ph <= (ph + 1) % HALF;
      if (ph == HALF - 1) ref_clk_o <= ~ref_clk_o;
   end
   // Every eighth mark repeats the last polarity
   always @(posedge clk_i) begin
      if (ph == 0) begin
         mk       <= mk + 1;
         pol      <= (mk % 8 == 7) ? pol : ~pol;
         cc_pos_o <= {2{(mk % 8 == 7) ? pol : ~pol}};
         cc_neg_o <= {2{(mk % 8 == 7) ? ~pol : pol}};
      end else if (ph == 2) begin
         cc_pos_o <= 2'h0;
         cc_neg_o <= 2'h0;
      end
   end
endmodule : icl_ref_src
`default_nettype wire

/* File: verif/icl_top_bench.sv */
// Purpose: Self-checking bench for icl_top
// Assumes: Both straps high in the first reset, low in the second
// Notes:   Tick counts allow one tick of slack
`timescale 1ns/1ps
`default_nettype none
module icl_top_bench;
   typedef struct packed {
      logic        we;
      logic [7:0]  adr;
      logic [31:0] dat;
   } icl_row_s;
   // ---------------------
   // Signals
   // ---------------------
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [7:0]  adr   = 8'h00;
   logic [31:0] wdat  = 32'h0;
   logic        we    = 1'b0;
   logic        cyc   = 1'b0;
   logic        strap = 1'b1;
   logic [31:0] dat_o, rd;
   logic        ack;
   logic [13:0] ref_clk, tick, l8k;
   logic [1:0]  ccp, ccn;
   int          miscompares = 0;
   int          checks_done = 0;
   int          cycles = 0;
   int          ticks [14];
   int          snap [14];
   logic [7:0]  mv [5] = '{8'h02, 8'h12, 8'h20, 8'h30, 8'h10};
   logic        me [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
   icl_row_s    rows [9] = '{'{1'b0, 8'h00, 32'h1}, '{1'b0, 8'h0C, 32'h1},
      '{1'b0, 8'h10, 32'h2}, '{1'b0, 8'h24, 32'h6}, '{1'b0, 8'h38, 32'h6},
      '{1'b0, 8'h44, 32'h3}, '{1'b0, 8'hFC, 32'h0}, '{1'b0, 8'h48, 32'h30000},
      '{1'b1, 8'h0C, 32'h2}};
   icl_top icl_top_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
      .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_we_i(we),
      .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .regional_rate_select_i(strap), .primary_secondary_select_i(strap),
      .ref_clk_i(ref_clk), .cc_pos_i(ccp), .cc_neg_i(ccn),
      .lock_tick_o(tick), .lock_at_8k_o(l8k));
   icl_ref_src icl_ref_src_inst (.clk_i(clk_i), .ref_clk_o(ref_clk),
      .cc_pos_o(ccp), .cc_neg_o(ccn));
   always #12.5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      for (int i = 0; i < 14; i++) ticks[i] <= ticks[i] + int'(tick[i]);
      if (cycles == 5000) begin
         miscompares++;
         conclude();
      end
   end
   // ---------------------
   // Tasks
   // ---------------------
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      we   <= w;
      adr  <= a;
      wdat <= d;
      cyc  <= 1'b1;
      do @(posedge clk_i); while (ack !== 1'b1);
      rd = dat_o;
      cyc <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_ticks(input int i, input int exp);
      int n;
      n = ticks[i] - snap[i];
      checks_done++;
      if (n < exp - 1 || n > exp + 1) begin
         miscompares++;
         $display("CHECK FAILED t=%0t input %0d ticks %0d", $time, i, n);
      end
   endtask : chk_ticks
   task automatic run(input int n);
      snap = ticks;
      repeat (n) @(posedge clk_i);
   endtask : run
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude
   // ---------------------
   // Sequence
   // ---------------------
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      foreach (rows[i]) begin
         wb(rows[i].we, rows[i].adr, rows[i].dat);
         if (!rows[i].we) chk(rd, rows[i].dat);
      end
      $display("register rows done");
      foreach (mv[i]) begin
         wb(1'b1, 8'h1C, {24'h0, mv[i]});
         @(posedge clk_i);
         chk({31'h0, l8k[3]}, {31'h0, me[i]});
      end
      $display("mode decode done");
      wb(1'b1, 8'h1C, 32'h20);
      wb(1'b1, 8'h20, 32'h20);
      wb(1'b1, 8'h08, 32'h1);
      wb(1'b1, 8'h24, 32'hB);
      wb(1'b1, 8'h28, 32'h12);
      wb(1'b1, 8'h2C, 32'h16);
      wb(1'b1, 8'h30, 32'hB);
      wb(1'b1, 8'h40, 32'h13);
      run(256);
      chk_ticks(2, 32);
      chk_ticks(3, 11);
      chk_ticks(4, 11);
      chk_ticks(0, 8);
      chk_ticks(5, 16);
      chk_ticks(6, 32);
      chk_ticks(7, 0);
      chk_ticks(8, 0);
      wb(1'b0, 8'h48, 32'h0);
      chk(rd, 32'h10DB_0100);
      wb(1'b1, 8'h04, 32'h1);
      run(256);
      chk_ticks(0, 32);
      chk({31'h0, l8k[0]}, 32'h0);
      $display("divider tests done");
      rst_i <= 1'b1;
      strap <= 1'b0;
      repeat (10) @(posedge clk_i);
      chk({18'h0, l8k}, 32'h0);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b0, 8'h1C, 32'h0);
      chk(rd, 32'h2);
      wb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0);
      wb(1'b0, 8'h38, 32'h0);
      chk(rd, 32'h5);
      $display("second reset done");
      conclude();
   end
endmodule : icl_top_bench
`default_nettype wire
